/* verilog/msg_link_defines.svh */
// constants shared by both ends of the serial message link
`ifndef MSG_LINK_DEFINES_SVH
`define MSG_LINK_DEFINES_SVH
`define OP_PROTO_INFO 8'h01
`define OP_PROTO_CFG 8'h02
`define OP_CTRL_WRITE 8'h03
`define OP_QUEUE_LEVEL 8'h04
`define OP_NOTICE_READ 8'h05
`define OP_SAMPLE_READ 8'h06
`define CFG_MEAS_EVT_BIT 3
`define CFG_NOTICE_EVT_BIT 2
`define CFG_DRIVE_TYPE_BIT 1
`define CFG_POLARITY_BIT 0
`define CFG_RESET 8'h0C
`define CFG_WRITE_MASK 8'h0F
`define PROTO_VERSION 8'h01
`define SUM_INIT 8'hFF
`define FILL_BYTE 8'hFF
`define MAX_MSG_BYTES 10'h200
`define STRAP_DEFAULT 3'h7
`define ADDR_S0 7'h1D
`define ADDR_S1 7'h1E
`define ADDR_S2 7'h28
`define ADDR_S3 7'h29
`define ADDR_S4 7'h68
`define ADDR_S5 7'h69
`define ADDR_S6 7'h6A
`define ADDR_S7 7'h6B
`define HOST_CMD_OFS 8'h00
`define HOST_STAT_OFS 8'h04
`define HC_START 3'h1
`define HC_WRITE 3'h2
`define HC_READ_ACK 3'h3
`define HC_READ_NACK 3'h4
`define HC_STOP 3'h5
`define CLK_PERIOD_NS 5
`define SCL_QUARTER_NS 625
`define SCL_QUARTER_CYC \
   ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* verilog/msg_link_pkg.sv */
// state types for both link ends
package msg_link_pkg;
   typedef enum logic [4:0] {
      SL_IDLE = 5'h01,
      SL_ADDR = 5'h02,
      SL_WRITE = 5'h04,
      SL_READ = 5'h08,
      SL_SKIP = 5'h10
   } slave_state_t;
   typedef enum logic [3:0] {
      MS_IDLE = 4'h1,
      MS_START = 4'h2,
      MS_BITS = 4'h4,
      MS_STOP = 4'h8
   } master_state_t;
endpackage : msg_link_pkg

/* verilog/msg_link_if.sv */
// two-wire link plus ready line between host and device
`timescale 1ns/1ps
interface msg_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic dev_ready_o;
   logic dev_ready_oe;
   logic scl;
   logic sda;
   logic ready_line;
   // open-drain wires with pull-ups
   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
                (dev_sda_oe ? dev_sda_o : 1'b1);
   assign ready_line = dev_ready_oe ? dev_ready_o : 1'b1;
   modport device(input scl, input sda, output dev_sda_o,
                  output dev_sda_oe, output dev_ready_o,
                  output dev_ready_oe);
   modport host(input scl, input sda, input ready_line,
                output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : msg_link_if

/* verilog/sync_serial_message_slave.sv */
// device end: message-layer slave on the two-wire link
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "msg_link_defines.svh"
// Function
// - device only answers, host drives everything
// - messages travel without preamble and bus identifier
// - checksum counts bus identifier as 0xFF
// - acknowledge must be read back by host
// - ready line high while any queue holds
// - bits 3,2 enable queue events
// - bit 1 selects push-pull or open drain
// - bit 0 selects idle polarity, 0 low
// - opcode 0x01 returns version and config
// - opcode 0x02 byte becomes new config
// - opcode 0x03 bytes form one control message
// - opcode 0x04 returns two little-endian sizes
// - opcode 0x05 returns one notice message
// - opcode 0x06 returns one sample message
// - open straps read as all ones
// - straps select one of eight addresses
// - first written byte is the opcode
// - over 512 bytes restarts receive buffer
module sync_serial_message_slave
   import msg_link_pkg::*;
#(
   parameter logic [7:0] proto_version = `PROTO_VERSION
) (
   input wire logic pclk,
   input wire logic presetn,
   msg_link_if.device link,
   input wire logic addr_strap_a0,
   input wire logic addr_strap_a1,
   input wire logic addr_strap_a2,
   input wire logic [15:0] notice_msg_size,
   input wire logic [15:0] sample_msg_size,
   input wire logic [7:0] queue_rd_data,
   output logic queue_rd_strobe,
   output logic queue_rd_sel,
   output logic [7:0] ctrl_byte,
   output logic ctrl_byte_valid,
   output logic ctrl_msg_done,
   output logic ctrl_msg_sum_ok,
   output logic ctrl_buf_reset,
   output logic [7:0] ready_line_config,
   output logic [6:0] slave_addr
);
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic [2:0] strap_meta_reg;
   logic [2:0] strap_sync_reg;
   logic [1:0] strap_cnt_reg;
   logic [6:0] addr_reg;
   slave_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] opcode_reg;
   logic first_reg;
   logic cfg_done_reg;
   logic [2:0] rd_idx_reg;
   logic sda_oe_reg;
   logic [7:0] cfg_reg;
   logic [9:0] ctrl_cnt_reg;
   logic [7:0] sum_reg;
   logic [7:0] ctrl_byte_reg;
   logic ctrl_valid_reg;
   logic ctrl_done_reg;
   logic ctrl_ok_reg;
   logic buf_reset_reg;
   logic pop_reg;
   logic ready_level_reg;
   logic scl_s;
   logic sda_s;
   logic start_c;
   logic stop_c;
   logic scl_rise;
   logic scl_fall;
   logic notice_pend;
   logic sample_pend;
   logic [7:0] next_byte;
   logic next_pop;

   // address table indexed by {a2,a1,a0}
   function automatic logic [6:0] addr_lookup(input logic [2:0] s);
      logic [6:0] a;
      unique case (s)
         3'h0: a = `ADDR_S0;
         3'h1: a = `ADDR_S1;
         3'h2: a = `ADDR_S2;
         3'h3: a = `ADDR_S3;
         3'h4: a = `ADDR_S4;
         3'h5: a = `ADDR_S5;
         3'h6: a = `ADDR_S6;
         3'h7: a = `ADDR_S7;
      endcase
      return a;
   endfunction : addr_lookup

   // two-flop synchronisers for link pins and straps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         strap_meta_reg <= `STRAP_DEFAULT;
         strap_sync_reg <= `STRAP_DEFAULT;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], link.scl};
         sda_sync_reg <= {sda_sync_reg[0], link.sda};
         scl_d_reg <= scl_sync_reg[1];
         sda_d_reg <= sda_sync_reg[1];
         strap_meta_reg <= {addr_strap_a2, addr_strap_a1, addr_strap_a0};
         strap_sync_reg <= strap_meta_reg;
      end
   end

   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];
   // bus conditions seen on the synchronised pins
   assign start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;

   // straps caught once after reset release, then frozen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_reg <= 2'h0;
         addr_reg <= `ADDR_S7;
      end else if (strap_cnt_reg != 2'h3) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == 2'h2) begin
            addr_reg <= addr_lookup(strap_sync_reg);
         end
      end
   end

   // read source chosen by the last written opcode
   always_comb begin
      next_byte = `FILL_BYTE;
      next_pop = 1'b0;
      case (opcode_reg)
         `OP_PROTO_INFO: begin
            if (rd_idx_reg == 3'h0) next_byte = proto_version;
            else if (rd_idx_reg == 3'h1) next_byte = cfg_reg;
         end
         `OP_QUEUE_LEVEL: begin
            unique case (rd_idx_reg)
               3'h0: next_byte = notice_msg_size[7:0];
               3'h1: next_byte = notice_msg_size[15:8];
               3'h2: next_byte = sample_msg_size[7:0];
               3'h3: next_byte = sample_msg_size[15:8];
               default: next_byte = `FILL_BYTE;
            endcase
         end
         `OP_NOTICE_READ: begin
            if (notice_pend) begin
               next_byte = queue_rd_data;
               next_pop = 1'b1;
            end
         end
         `OP_SAMPLE_READ: begin
            if (sample_pend) begin
               next_byte = queue_rd_data;
               next_pop = 1'b1;
            end
         end
         default: next_byte = `FILL_BYTE;
      endcase
   end

   // link state machine; never stretches the clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SL_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'hFF;
         opcode_reg <= 8'h00;
         first_reg <= 1'b0;
         cfg_done_reg <= 1'b0;
         rd_idx_reg <= 3'h0;
         sda_oe_reg <= 1'b0;
         cfg_reg <= `CFG_RESET;
         ctrl_cnt_reg <= 10'h000;
         sum_reg <= `SUM_INIT;
         ctrl_byte_reg <= 8'h00;
         ctrl_valid_reg <= 1'b0;
         ctrl_done_reg <= 1'b0;
         ctrl_ok_reg <= 1'b0;
         buf_reset_reg <= 1'b0;
         pop_reg <= 1'b0;
      end else begin
         ctrl_valid_reg <= 1'b0;
         ctrl_done_reg <= 1'b0;
         buf_reset_reg <= 1'b0;
         pop_reg <= 1'b0;
         if (start_c || stop_c) begin
            // a message ends at stop or repeated start
            if (state_reg == SL_WRITE && !first_reg &&
                opcode_reg == `OP_CTRL_WRITE &&
                ctrl_cnt_reg != 10'h000) begin
               ctrl_done_reg <= 1'b1;
               ctrl_ok_reg <= (sum_reg == 8'h00);
            end
            state_reg <= start_c ? SL_ADDR : SL_IDLE;
            bit_cnt_reg <= 4'h8; // start's own scl fall wraps to bit 0
            sda_oe_reg <= 1'b0;
         end else if (state_reg != SL_IDLE && state_reg != SL_SKIP) begin
            if (scl_rise && bit_cnt_reg < 4'h8) begin
               shift_reg <= {shift_reg[6:0], sda_s};
            end
            // master nack after a read byte ends the read
            if (scl_rise && bit_cnt_reg == 4'h8 && state_reg == SL_READ &&
                sda_s) begin
               state_reg <= SL_SKIP;
            end
            if (scl_fall) begin
               bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 :
                              bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == 4'h7) begin
                  if (state_reg == SL_ADDR) begin
                     if (shift_reg[7:1] == addr_reg) begin
                        sda_oe_reg <= 1'b1;
                        state_reg <= shift_reg[0] ? SL_READ : SL_WRITE;
                        first_reg <= ~shift_reg[0];
                        rd_idx_reg <= 3'h0;
                     end else begin
                        state_reg <= SL_SKIP;
                     end
                  end else if (state_reg == SL_WRITE) begin
                     sda_oe_reg <= 1'b1;
                     if (first_reg) begin
                        opcode_reg <= shift_reg;
                        first_reg <= 1'b0;
                        cfg_done_reg <= 1'b0;
                        ctrl_cnt_reg <= 10'h000;
                        sum_reg <= `SUM_INIT;
                     end else if (opcode_reg == `OP_PROTO_CFG) begin
                        // only the first byte counts; reserved bits drop
                        if (!cfg_done_reg) begin
                           cfg_reg <= shift_reg & `CFG_WRITE_MASK;
                           cfg_done_reg <= 1'b1;
                        end
                     end else if (opcode_reg == `OP_CTRL_WRITE) begin
                        ctrl_byte_reg <= shift_reg;
                        ctrl_valid_reg <= 1'b1;
                        if (ctrl_cnt_reg == `MAX_MSG_BYTES) begin
                           buf_reset_reg <= 1'b1;
                           ctrl_cnt_reg <= 10'h001;
                           sum_reg <= `SUM_INIT + shift_reg;
                        end else begin
                           ctrl_cnt_reg <= ctrl_cnt_reg + 10'h001;
                           sum_reg <= sum_reg + shift_reg;
                        end
                     end
                  end else begin
                     sda_oe_reg <= 1'b0; // let the master acknowledge
                  end
               end else if (bit_cnt_reg == 4'h8 && state_reg == SL_READ) begin
                  // fetch next byte; host pulls, device never pushes
                  tx_reg <= {next_byte[6:0], 1'b1};
                  sda_oe_reg <= ~next_byte[7];
                  pop_reg <= next_pop;
                  if (rd_idx_reg != 3'h4) rd_idx_reg <= rd_idx_reg + 3'h1;
               end else if (bit_cnt_reg == 4'h8) begin
                  sda_oe_reg <= 1'b0;
               end else if (state_reg == SL_READ) begin
                  sda_oe_reg <= ~tx_reg[7];
                  tx_reg <= {tx_reg[6:0], 1'b1};
               end
            end
         end
      end
   end

   assign notice_pend = notice_msg_size != 16'h0000;
   assign sample_pend = sample_msg_size != 16'h0000;

   // ready level, registered so the pin never glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_level_reg <= 1'b0;
      end else begin
         ready_level_reg <=
            ((cfg_reg[`CFG_MEAS_EVT_BIT] & sample_pend) |
             (cfg_reg[`CFG_NOTICE_EVT_BIT] & notice_pend)) ^
            cfg_reg[`CFG_POLARITY_BIT];
      end
   end

   // open drain only pulls low; push-pull always drives
   assign link.dev_ready_o = cfg_reg[`CFG_DRIVE_TYPE_BIT] ? 1'b0 :
                             ready_level_reg;
   assign link.dev_ready_oe = cfg_reg[`CFG_DRIVE_TYPE_BIT] ?
                              ~ready_level_reg : 1'b1;
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = sda_oe_reg;
   assign queue_rd_strobe = pop_reg;
   assign queue_rd_sel = (opcode_reg == `OP_SAMPLE_READ);
   assign ctrl_byte = ctrl_byte_reg;
   assign ctrl_byte_valid = ctrl_valid_reg;
   assign ctrl_msg_done = ctrl_done_reg;
   assign ctrl_msg_sum_ok = ctrl_ok_reg;
   assign ctrl_buf_reset = buf_reset_reg;
   assign ready_line_config = cfg_reg;
   assign slave_addr = addr_reg;
endmodule : sync_serial_message_slave

/* verilog/sync_serial_message_master.sv */
// host end: byte-level two-wire master under APB control
`timescale 1ns/1ps
`include "msg_link_defines.svh"
module sync_serial_message_master
   import msg_link_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   msg_link_if.host link
);
   master_state_t state_reg;
   logic [7:0] div_cnt_reg;
   logic qtick_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic rd_reg;
   logic ack_drive_reg;
   logic ack_seen_reg;
   logic scl_oe_reg;
   logic sda_oe_reg;
   logic [7:0] sum_reg;
   logic [1:0] byte_no_reg;
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic [1:0] rdy_sync_reg;
   logic cmd_wr;
   logic step;
   logic [2:0] cmd;

   // link pins cross into pclk through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         rdy_sync_reg <= 2'h0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], link.scl};
         sda_sync_reg <= {sda_sync_reg[0], link.sda};
         rdy_sync_reg <= {rdy_sync_reg[0], link.ready_line};
      end
   end

   // quarter-bit enable from the divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 8'h00;
         qtick_reg <= 1'b0;
      end else if (div_cnt_reg == 8'(`SCL_QUARTER_CYC - 1)) begin
         div_cnt_reg <= 8'h00;
         qtick_reg <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
         qtick_reg <= 1'b0;
      end
   end

   // commands taken in the access phase; refused while busy
   assign cmd_wr = psel & penable & pwrite & (paddr == `HOST_CMD_OFS) &
                   (state_reg == MS_IDLE);
   assign cmd = pwdata[2:0];
   // waiting in phase 2 honours a slave holding the clock low
   assign step = qtick_reg & (phase_reg != 2'h2 | scl_sync_reg[1]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= MS_IDLE;
         phase_reg <= 2'h0;
         bit_cnt_reg <= 4'h0;
         tx_reg <= 8'h00;
         rx_reg <= 8'h00;
         rd_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         sum_reg <= `SUM_INIT;
         byte_no_reg <= 2'h0;
      end else if (cmd_wr) begin
         // every exchange starts here, never at the device
         phase_reg <= 2'h0;
         bit_cnt_reg <= 4'h0;
         tx_reg <= pwdata[15:8];
         rd_reg <= (cmd == `HC_READ_ACK) | (cmd == `HC_READ_NACK);
         ack_drive_reg <= (cmd == `HC_READ_ACK);
         if (cmd == `HC_START) begin
            state_reg <= MS_START;
            sum_reg <= `SUM_INIT;
            byte_no_reg <= 2'h0;
         end else if (cmd == `HC_STOP) begin
            state_reg <= MS_STOP;
         end else if (cmd == `HC_WRITE) begin
            state_reg <= MS_BITS;
            // bytes after the opcode join the checksum
            if (byte_no_reg != 2'h0) begin
               sum_reg <= sum_reg + pwdata[15:8];
            end else begin
               byte_no_reg <= 2'h1;
            end
         end else if (cmd != 3'h0) begin
            state_reg <= MS_BITS;
         end
      end else if (step && state_reg != MS_IDLE) begin
         phase_reg <= phase_reg + 2'h1;
         unique case (state_reg)
            MS_START: begin
               if (phase_reg == 2'h0) sda_oe_reg <= 1'b0;
               else if (phase_reg == 2'h1) scl_oe_reg <= 1'b0;
               else if (phase_reg == 2'h2) sda_oe_reg <= 1'b1;
               else begin
                  scl_oe_reg <= 1'b1;
                  state_reg <= MS_BITS;
               end
            end
            MS_BITS: begin
               if (phase_reg == 2'h0) begin
                  sda_oe_reg <= (bit_cnt_reg < 4'h8) ?
                                (~rd_reg & ~tx_reg[7]) :
                                (rd_reg & ack_drive_reg);
               end else if (phase_reg == 2'h1) begin
                  scl_oe_reg <= 1'b0;
               end else if (phase_reg == 2'h2) begin
                  if (bit_cnt_reg < 4'h8) begin
                     rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end else begin
                     ack_seen_reg <= ~sda_sync_reg[1];
                  end
               end else begin
                  scl_oe_reg <= 1'b1;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == 4'h8) state_reg <= MS_IDLE;
               end
            end
            MS_STOP: begin
               if (phase_reg == 2'h0) sda_oe_reg <= 1'b1;
               else if (phase_reg == 2'h1) scl_oe_reg <= 1'b0;
               else if (phase_reg == 2'h2) sda_oe_reg <= 1'b0;
               else state_reg <= MS_IDLE;
            end
            default: state_reg <= MS_IDLE;
         endcase
      end
   end

   // zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & (paddr != `HOST_CMD_OFS) &
                    (paddr != `HOST_STAT_OFS);
   assign prdata = (paddr == `HOST_STAT_OFS) ?
                   {sum_reg, 8'h00, rx_reg, 5'h00, rdy_sync_reg[1],
                    ack_seen_reg, state_reg != MS_IDLE} : 32'h00000000;
   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe = scl_oe_reg;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = sda_oe_reg;
endmodule : sync_serial_message_master

/* tb/link_monitor.sv */
// checker for the shared two-wire link between host and device
`timescale 1ns/1ps
module link_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic dev_ready_o,
   input wire logic dev_ready_oe
);
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // device only sinks sda, never drives it high
   a_dev_sda_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device drives sda high");
   a_start_by_host: assert property ($fell(sda) && scl |-> host_sda_oe)
      else $error("start made by device");
   a_stop_by_host: assert property ($rose(sda) && scl |-> $past(host_sda_oe))
      else $error("stop made by device");
   // a slave may only move sda while scl is low
   a_sda_steady_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda moved with scl high");
   a_sda_late_move: assert property ($changed(dev_sda_oe) |-> !scl && $past(!scl, 2))
      else $error("device sda moved too soon");
   a_ready_drain: assert property (!dev_ready_oe |-> !dev_ready_o)
      else $error("ready line released high");
   // host alone times the clock; device never stretches
   a_scl_high_hold: assert property ($rose(scl) |=> scl [*8])
      else $error("scl high phase too short");
   a_scl_low_hold: assert property ($fell(scl) |=> !scl [*8])
      else $error("scl low phase too short");
endmodule : link_monitor

/* tb/tb.sv */
// bench joining host and device ends over the link
`timescale 1ns/1ps
`include "msg_link_defines.svh"
module tb;
   import msg_link_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 0, qd = 0, rcfg, cbyte;
   logic [31:0] pwdata = 0, prdata, st;
   logic pready, pslverr, strobe, sel, cval, cdone, csum, creset;
   logic [2:0] s = 3'h7;
   logic [15:0] nsz = 0, ssz = 0;
   logic [6:0] saddr;
   logic [7:0] cq [$];
   logic [6:0] atab [8] = '{7'h1D, 7'h1E, 7'h28, 7'h29,
                            7'h68, 7'h69, 7'h6A, 7'h6B};
   int n_errors = 0, n_tests = 0, cyc = 0, ndone = 0, npop = 0;
   msg_link_if msg_link_if_inst();
   sync_serial_message_master sync_serial_message_master_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(msg_link_if_inst));
   sync_serial_message_slave sync_serial_message_slave_inst (.pclk(pclk),
      .presetn(presetn), .link(msg_link_if_inst), .addr_strap_a0(s[0]),
      .addr_strap_a1(s[1]), .addr_strap_a2(s[2]), .notice_msg_size(nsz),
      .sample_msg_size(ssz), .queue_rd_data(qd), .queue_rd_strobe(strobe),
      .queue_rd_sel(sel), .ctrl_byte(cbyte), .ctrl_byte_valid(cval),
      .ctrl_msg_done(cdone), .ctrl_msg_sum_ok(csum),
      .ctrl_buf_reset(creset), .ready_line_config(rcfg), .slave_addr(saddr));
   link_monitor link_monitor_inst (.pclk(pclk), .presetn(presetn),
      .scl(msg_link_if_inst.scl), .sda(msg_link_if_inst.sda),
      .host_scl_oe(msg_link_if_inst.host_scl_oe),
      .host_sda_oe(msg_link_if_inst.host_sda_oe),
      .dev_sda_o(msg_link_if_inst.dev_sda_o),
      .dev_sda_oe(msg_link_if_inst.dev_sda_oe),
      .dev_ready_o(msg_link_if_inst.dev_ready_o),
      .dev_ready_oe(msg_link_if_inst.dev_ready_oe));
   // clock and hang guard; 17 link bytes need about 85k cycles
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 100000) begin
         n_errors++;
         test_done();
      end
   end
   // collect control bytes as the device hands them on
   always @(posedge pclk) begin
      if (cval === 1'b1) cq.push_back(cbyte);
      if (cdone === 1'b1) ndone++;
      if (strobe === 1'b1) npop++;
   end
   task automatic test_done;
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task automatic check(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // read data is taken at the edge that completes the access
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // one link step, then poll busy until it clears
   task automatic cmd(logic [2:0] c, logic [7:0] b);
      apb(1, `HOST_CMD_OFS, {16'h0, b, 5'h0, c}, st);
      do apb(0, `HOST_STAT_OFS, 0, st); while (st[0] !== 1'b0);
   endtask : cmd
   task automatic rd2(logic [7:0] op, output logic [7:0] b0, b1);
      cmd(`HC_START, 8'hD6);
      cmd(`HC_WRITE, op);
      cmd(`HC_START, 8'hD7);
      cmd(`HC_READ_ACK, 0);
      b0 = st[15:8];
      cmd(`HC_READ_NACK, 0);
      b1 = st[15:8];
      cmd(`HC_STOP, 0);
   endtask : rd2
   initial begin
      logic [31:0] r;
      logic [7:0] b0, b1, cfg, m0, m1;
      logic lv;
      void'($urandom(78));
      qd <= 8'($urandom);
      // every strap setting, ending on the open-pin default
      for (int i = 0; i < 8; i++) begin
         presetn <= 0;
         s <= 3'(i);
         repeat (2) @(posedge pclk);
         presetn <= 1;
         repeat (5) @(posedge pclk);
         check("slave_addr", 16'(atab[i]), 16'(saddr));
      end
      check("cfg_reset", 16'(`CFG_RESET), 16'(rcfg));
      check("ready_idle", 16'h0, 16'(msg_link_if_inst.ready_line));
      repeat (10) @(posedge pclk);
      apb(0, 8'h08, 0, r);
      check("unmapped", 16'h1, {15'h0, err});
      cfg = 8'($urandom);
      cmd(`HC_START, 8'hD6);
      check("addr_ack", 16'h1, 16'(st[1]));
      cmd(`HC_WRITE, `OP_PROTO_CFG);
      cmd(`HC_WRITE, cfg);
      cmd(`HC_STOP, 0);
      cfg = cfg & `CFG_WRITE_MASK;
      check("config", 16'(cfg), 16'(rcfg));
      rd2(`OP_PROTO_INFO, b0, b1);
      check("version", 16'(`PROTO_VERSION), 16'(b0));
      check("info_cfg", 16'(cfg), 16'(b1));
      // control message whose checksum closes to zero
      m0 = 8'($urandom);
      m1 = 8'h01 - m0;
      cmd(`HC_START, 8'hD6);
      cmd(`HC_WRITE, `OP_CTRL_WRITE);
      cmd(`HC_WRITE, m0);
      cmd(`HC_WRITE, m1);
      check("host_sum", 16'h0, 16'(st[31:24]));
      cmd(`HC_STOP, 0);
      repeat (10) @(posedge pclk);
      check("ctrl_count", 16'h2, 16'(cq.size()));
      check("ctrl_b0", 16'(m0), 16'(cq[0]));
      check("ctrl_b1", 16'(m1), 16'(cq[1]));
      check("ctrl_done", 16'h1, 16'(ndone));
      check("ctrl_sum", 16'h1, 16'(csum));
      // ready line over every queue occupancy
      for (int i = 0; i < 4; i++) begin
         nsz <= i[0] ? 16'($urandom) | 16'h1 : 16'h0;
         ssz <= i[1] ? 16'($urandom) | 16'h1 : 16'h0;
         repeat (3) @(posedge pclk);
         lv = ((cfg[3] & i[1]) | (cfg[2] & i[0])) ^ cfg[0];
         check("ready", 16'(lv), 16'(msg_link_if_inst.ready_line));
         check("ready_oe", cfg[1] ? 16'(!lv) : 16'h1,
               16'(msg_link_if_inst.dev_ready_oe));
         apb(0, `HOST_STAT_OFS, 0, st);
         check("ready_stat", 16'(lv), 16'(st[2]));
      end
      rd2(`OP_QUEUE_LEVEL, b0, b1);
      check("notice_size", nsz, {b1, b0});
      check("queue_pops", 16'h0, 16'(npop));
      check("queue_sel", 16'h0, 16'(sel));
      test_done();
   end
endmodule : tb
